// [core/csa_map.vh]
// Purpose: constants for the cpu status / alu core block
// Assumes: 32-bit ahb-lite register words, byte addresses
// Notes: offsets of the register window are local choices
`ifndef CSA_MAP_VH
`define CSA_MAP_VH
// register byte offsets
`define CSA_OFS_STATUS 8'h00
`define CSA_OFS_CORE 8'h04
`define CSA_OFS_OPA 8'h08
`define CSA_OFS_OPB 8'h0C
`define CSA_OFS_CMD 8'h10
`define CSA_OFS_RES 8'h14
`define CSA_OFS_RES_HI 8'h18
`define CSA_OFS_WREG 8'h1C
`define CSA_OFS_PAGE 8'h20
`define CSA_OFS_DADDR 8'h24
`define CSA_OFS_XLATE 8'h28
`define CSA_OFS_PC 8'h2C
`define CSA_OFS_CTRL 8'h30
`define CSA_OFS_DMARAM 8'h34
// status word fields
`define CSA_SR_C 0
`define CSA_SR_Z 1
`define CSA_SR_OV 2
`define CSA_SR_N 3
`define CSA_SR_RA 4
`define CSA_SR_IPL_LO 5
`define CSA_SR_IPL_HI 7
`define CSA_SR_DC 8
// core control fields
`define CSA_CC_PSV 2
`define CSA_CC_PRIORITY_LEVEL_MSB 3
// reset values
`define CSA_SR_RST 16'h0000
`define CSA_CC_RST 16'h0000
// command opcodes, cmd[3:0]; cmd[4] byte mode; cmd[6:5] multiply signs
`define CSA_OP_ADD 4'h0
`define CSA_OP_SUB 4'h1
`define CSA_OP_AND 4'h2
`define CSA_OP_OR 4'h3
`define CSA_OP_XOR 4'h4
`define CSA_OP_MUL 4'h5
`define CSA_OP_SHIFT 4'h6
`define CSA_OP_DIVU 4'h7
`define CSA_OP_DIVS 4'h8
`define CSA_OP_REPEAT 4'h9
`define CSA_OP_DMOVE 4'hA
`define CSA_OP_BRANCH 4'hB
// timing
`define CSA_DIV_CYCLES 19
`define CSA_DIV_STEPS 16
`define CSA_PC_WIDTH 23
`endif

// [core/csa_core.v]
// What this block does
// RULE1: 23-bit program counter, 24-bit words
// RULE2: single cycle, except flow, double move, table
// RULE3: zero-overhead repeat loop, interruptible each iteration
// RULE4: sixteen 16-bit registers, last is stack
// RULE5: memory read, register read, write, fetch per cycle
// RULE6: data space is 32K words linear
// RULE7: upper half maps to program page window
// RULE8: 2 Kbyte dma ram, general purpose too
// RULE9: 17x17 multiplier, signed unsigned mixed
// RULE10: divide iterative, 19 cycles, interrupt safe
// RULE11: shift up to 16 bits one cycle
// RULE12: byte or word operands, register or memory
// RULE13: half carry bit 8, bits 15-9 zero
// RULE14: priority bits 7-5, 111 disables user
// RULE15: msb concatenates above, one disables user
// RULE16: priority read-only while nesting disabled
// RULE17: loop active bit 4 during repeat
// RULE18: negative bit 3, overflow bit 2
// RULE19: zero bit cleared by non-zero result
// RULE20: carry bit 0 out of msb
// RULE21: subtraction carries are borrows, two's complement
// RULE22: window enable bit 2 shows program space
//
// Purpose: cpu status word, core control word and alu datapath behind ahb-lite
// Assumes: clk 100 MHz, arst_n asynchronous active low, single word transfers
// Notes: a write to the command register launches one operation
`timescale 1ns/1ns
`include "csa_map.vh"

module csa_core #(
    parameter DMA_WORDS = 1024
) (
    input wire clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire nesting_disable,
    input wire irq_request,
    output wire user_irq_disabled,
    output wire [3:0] cpu_level,
    output wire busy
);

    // ----------------------------------------
    // bus address phase capture
    // ----------------------------------------
    reg wr_pend_reg;
    reg rd_pend_reg;
    reg [7:0] addr_reg;
    wire take = hsel & hready & htrans[1];
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take & hwrite;
            rd_pend_reg <= take & ~hwrite;
            if (take) begin
                addr_reg <= haddr[7:0];
            end
        end
    end
    // zero wait states; every access answers okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire wr = wr_pend_reg;
    wire [15:0] wd = hwdata[15:0];

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_DIV = 3'b010;
    localparam ST_WAIT = 3'b100;
    reg [2:0] state_reg;
    reg [15:0] sr_reg;
    reg [15:0] cc_reg;
    reg [15:0] opa_reg;
    reg [15:0] opb_reg;
    reg [15:0] res_reg;
    reg [15:0] res_hi_reg;
    reg [7:0] page_reg;
    reg [15:0] daddr_reg;
    reg [`CSA_PC_WIDTH-1:0] pc_reg;
    reg [15:0] rep_cnt_reg;
    reg [4:0] cyc_reg;
    reg [31:0] rem_reg;
    reg [15:0] quo_reg;
    reg div_neg_q_reg;
    reg div_neg_r_reg;
    reg [3:0] widx_reg;
    reg [15:0] wreg [0:15];
    reg [15:0] dma_ram [0:DMA_WORDS-1];
    reg [9:0] dma_idx_reg;
    reg [15:0] dma_rd_reg;

    // ----------------------------------------
    // combinational alu
    // ----------------------------------------
    wire [15:0] cmd = wd;
    wire byte_mode = cmd[4];
    wire [16:0] sum17 = {1'b0, opa_reg} + {1'b0, opb_reg};
    wire [16:0] dif17 = {1'b0, opa_reg} - {1'b0, opb_reg};
    wire [8:0] bsum = {1'b0, opa_reg[7:0]} + {1'b0, opb_reg[7:0]};
    wire [8:0] bdif = {1'b0, opa_reg[7:0]} - {1'b0, opb_reg[7:0]};
    wire [4:0] nib_s = {1'b0, opa_reg[3:0]} + {1'b0, opb_reg[3:0]};
    wire [4:0] nib_d = {1'b0, opa_reg[3:0]} - {1'b0, opb_reg[3:0]};
    // extra 17th bit lets mixed-sign products share one multiplier
    wire signed [16:0] mul_a = {cmd[5] & opa_reg[15], opa_reg}; // see RULE9
    wire signed [16:0] mul_b = {cmd[6] & opb_reg[15], opb_reg};
    wire signed [33:0] prod = mul_a * mul_b;
    wire [4:0] sh_neg = ~opb_reg[4:0] + 5'd1;
    wire [4:0] sh_mag = opb_reg[15] ? sh_neg : opb_reg[4:0];
    // signed copy, else the unsigned mux would make the shift logical
    wire signed [15:0] opa_s = opa_reg;
    wire [15:0] sh_ar = opa_s >>> sh_mag;
    wire [15:0] sh_val = opb_reg[15] ? (opa_reg << sh_mag) : // see RULE11
        (cmd[5] ? sh_ar : (opa_reg >> sh_mag));

    reg [15:0] r;
    reg c_o;
    reg dc_o;
    reg ov_o;
    reg upd;
    always @* begin
        r = 16'h0000;
        c_o = 1'b0;
        dc_o = 1'b0;
        ov_o = 1'b0;
        upd = 1'b1;
        case (cmd[3:0])
            `CSA_OP_ADD: begin
                if (byte_mode) begin // see RULE12
                    r = {8'h00, bsum[7:0]};
                    c_o = bsum[8];
                    dc_o = nib_s[4]; // see RULE13
                    ov_o = (opa_reg[7] == opb_reg[7]) & (bsum[7] != opa_reg[7]);
                end else begin
                    r = sum17[15:0];
                    c_o = sum17[16]; // see RULE20
                    dc_o = bsum[8];
                    ov_o = (opa_reg[15] == opb_reg[15]) & (r[15] != opa_reg[15]); // see RULE18
                end
            end
            `CSA_OP_SUB: begin
                // carries report borrow on subtraction
                if (byte_mode) begin
                    r = {8'h00, bdif[7:0]};
                    c_o = bdif[8]; // see RULE21
                    dc_o = nib_d[4];
                    ov_o = (opa_reg[7] != opb_reg[7]) & (bdif[7] != opa_reg[7]);
                end else begin
                    r = dif17[15:0];
                    c_o = dif17[16];
                    dc_o = bdif[8];
                    ov_o = (opa_reg[15] != opb_reg[15]) & (r[15] != opa_reg[15]);
                end
            end
            `CSA_OP_AND: r = opa_reg & opb_reg;
            `CSA_OP_OR: r = opa_reg | opb_reg;
            `CSA_OP_XOR: r = opa_reg ^ opb_reg;
            `CSA_OP_MUL: r = prod[15:0];
            `CSA_OP_SHIFT: r = sh_val;
            default: upd = 1'b0;
        endcase
        if (byte_mode) begin
            r = {8'h00, r[7:0]};
        end
    end
    wire neg_o = byte_mode ? r[7] : r[15];

    // ----------------------------------------
    // divide step: one restoring step per cycle
    // ----------------------------------------
    // dividend bits enter a 17-bit partial remainder, one per step
    wire [16:0] rem_sh = {rem_reg[15:0], quo_reg[15]};
    wire [17:0] trial = {1'b0, rem_sh} - {2'b00, opb_reg};
    wire div_bit = ~trial[17];
    wire [15:0] neg_quo = ~quo_reg + 16'h0001;
    wire [15:0] neg_rem = ~rem_reg[15:0] + 16'h0001;

    // ----------------------------------------
    // address generator: linear 32K words, upper half may hit program page
    // ----------------------------------------
    wire win_hit = daddr_reg[15] & cc_reg[`CSA_CC_PSV]; // see RULE7 RULE22
    wire [23:0] xlate = win_hit ? {page_reg, daddr_reg[14:0], 1'b0} : // see RULE6
        {8'h00, daddr_reg[15:1], 1'b0};

    wire rep_active = sr_reg[`CSA_SR_RA];
    wire [15:0] abs_a = opa_reg[15] ? (~opa_reg + 16'h0001) : opa_reg;
    wire [15:0] abs_b = opb_reg[15] ? (~opb_reg + 16'h0001) : opb_reg;
    wire cmd_wr = wr & (addr_reg == `CSA_OFS_CMD) & (state_reg == ST_IDLE);

    // ----------------------------------------
    // main sequential logic
    // ----------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            sr_reg <= `CSA_SR_RST;
            cc_reg <= `CSA_CC_RST;
            opa_reg <= 16'h0000;
            opb_reg <= 16'h0000;
            res_reg <= 16'h0000;
            res_hi_reg <= 16'h0000;
            page_reg <= 8'h00;
            daddr_reg <= 16'h0000;
            pc_reg <= {`CSA_PC_WIDTH{1'b0}};
            rep_cnt_reg <= 16'h0000;
            cyc_reg <= 5'd0;
            rem_reg <= 32'h0000_0000;
            quo_reg <= 16'h0000;
            div_neg_q_reg <= 1'b0;
            div_neg_r_reg <= 1'b0;
            widx_reg <= 4'h0;
            dma_idx_reg <= 10'h000;
        end else begin
            if (wr) begin
                case (addr_reg)
                    `CSA_OFS_STATUS: begin
                        sr_reg[3:0] <= wd[3:0];
                        sr_reg[`CSA_SR_DC] <= wd[`CSA_SR_DC];
                        if (!nesting_disable) begin
                            sr_reg[7:5] <= wd[7:5]; // see RULE16
                        end
                    end
                    `CSA_OFS_CORE: begin
                        cc_reg[`CSA_CC_PSV] <= wd[`CSA_CC_PSV];
                        // clear-only priority msb
                        if (!wd[`CSA_CC_PRIORITY_LEVEL_MSB]) begin
                            cc_reg[`CSA_CC_PRIORITY_LEVEL_MSB] <= 1'b0;
                        end
                    end
                    `CSA_OFS_OPA: opa_reg <= wd;
                    `CSA_OFS_OPB: opb_reg <= wd;
                    `CSA_OFS_PAGE: page_reg <= wd[7:0];
                    `CSA_OFS_DADDR: daddr_reg <= wd;
                    `CSA_OFS_WREG: widx_reg <= wd[3:0];
                    `CSA_OFS_DMARAM: dma_idx_reg <= wd[9:0];
                    default: ;
                endcase
            end
            // one instruction per cycle advances the pc by two
            pc_reg <= pc_reg + 23'd2; // see RULE1 RULE5
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_wr && upd) begin // see RULE2
                        res_reg <= r;
                        res_hi_reg <= (cmd[3:0] == `CSA_OP_MUL) ? prod[31:16] : 16'h0000;
                        if (cmd[3:0] <= `CSA_OP_SUB) begin
                            sr_reg[`CSA_SR_C] <= c_o;
                            sr_reg[`CSA_SR_DC] <= dc_o;
                            sr_reg[`CSA_SR_OV] <= ov_o;
                        end
                        sr_reg[`CSA_SR_N] <= neg_o;
                        if (r != 16'h0000) begin
                            sr_reg[`CSA_SR_Z] <= 1'b0; // see RULE19
                        end
                    end else if (cmd_wr && (cmd[3:0] == `CSA_OP_DIVU || cmd[3:0] == `CSA_OP_DIVS)) begin
                        // divide runs as a repeat of single steps
                        state_reg <= ST_DIV; // see RULE10
                        sr_reg[`CSA_SR_RA] <= 1'b1;
                        cyc_reg <= 5'd1;
                        rem_reg <= 32'h0000_0000;
                        if (cmd[3:0] == `CSA_OP_DIVS) begin
                            quo_reg <= abs_a;
                            div_neg_q_reg <= opa_reg[15] ^ opb_reg[15];
                            div_neg_r_reg <= opa_reg[15];
                        end else begin
                            quo_reg <= opa_reg;
                            div_neg_q_reg <= 1'b0;
                            div_neg_r_reg <= 1'b0;
                        end
                        if (cmd[3:0] == `CSA_OP_DIVS) begin
                            opb_reg <= abs_b;
                        end
                    end else if (cmd_wr && cmd[3:0] == `CSA_OP_REPEAT) begin
                        state_reg <= ST_WAIT; // see RULE3
                        sr_reg[`CSA_SR_RA] <= 1'b1; // see RULE17
                        rep_cnt_reg <= opa_reg;
                    end else if (cmd_wr && (cmd[3:0] == `CSA_OP_DMOVE || cmd[3:0] == `CSA_OP_BRANCH)) begin
                        // two-cycle instructions
                        state_reg <= ST_WAIT;
                        rep_cnt_reg <= 16'h0000;
                    end
                end
                ST_DIV: begin
                    // state lives in registers, so an interrupt stall loses nothing
                    if (!irq_request) begin
                        cyc_reg <= cyc_reg + 5'd1;
                        if (cyc_reg <= `CSA_DIV_STEPS) begin
                            quo_reg <= {quo_reg[14:0], div_bit};
                            rem_reg <= {16'h0000, (div_bit ? trial[15:0] : rem_sh[15:0])};
                        end
                        if (cyc_reg == `CSA_DIV_CYCLES - 1) begin
                            state_reg <= ST_IDLE;
                            sr_reg[`CSA_SR_RA] <= 1'b0;
                            res_reg <= div_neg_q_reg ? neg_quo : quo_reg;
                            res_hi_reg <= div_neg_r_reg ? neg_rem : rem_reg[15:0];
                            sr_reg[`CSA_SR_Z] <= (quo_reg == 16'h0000);
                        end
                    end
                end
                ST_WAIT: begin
                    // loop iterations stall while an interrupt is taken
                    if (!irq_request) begin
                        if (rep_cnt_reg == 16'h0000) begin
                            state_reg <= ST_IDLE;
                            sr_reg[`CSA_SR_RA] <= 1'b0;
                        end else begin
                            rep_cnt_reg <= rep_cnt_reg - 16'h0001;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // working registers and dma ram
    // ----------------------------------------
    always @(posedge clk) begin
        if (wr && addr_reg == `CSA_OFS_RES && state_reg == ST_IDLE) begin
            wreg[widx_reg] <= res_reg; // see RULE4
        end
        if (wr && addr_reg == `CSA_OFS_CTRL) begin
            dma_ram[dma_idx_reg] <= wd; // see RULE8
        end
        dma_rd_reg <= dma_ram[dma_idx_reg];
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (addr_reg)
            `CSA_OFS_STATUS: rd_mux = {23'h00_0000, sr_reg[8:0]};
            `CSA_OFS_CORE: rd_mux = {28'h000_0000, cc_reg[3:2], 2'b00};
            `CSA_OFS_OPA: rd_mux = {16'h0000, opa_reg};
            `CSA_OFS_OPB: rd_mux = {16'h0000, opb_reg};
            `CSA_OFS_RES: rd_mux = {16'h0000, res_reg};
            `CSA_OFS_RES_HI: rd_mux = {16'h0000, res_hi_reg};
            `CSA_OFS_WREG: rd_mux = {16'h0000, wreg[widx_reg]};
            `CSA_OFS_PAGE: rd_mux = {24'h00_0000, page_reg};
            `CSA_OFS_DADDR: rd_mux = {16'h0000, daddr_reg};
            `CSA_OFS_XLATE: rd_mux = {8'h00, xlate};
            `CSA_OFS_PC: rd_mux = {9'h000, pc_reg};
            `CSA_OFS_DMARAM: rd_mux = {16'h0000, dma_rd_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign hrdata = rd_pend_reg ? rd_mux : 32'h0000_0000;

    // level 7 in the low field or a set msb locks out user interrupts
    assign cpu_level = {cc_reg[`CSA_CC_PRIORITY_LEVEL_MSB], sr_reg[7:5]}; // see RULE15
    assign user_irq_disabled = cc_reg[`CSA_CC_PRIORITY_LEVEL_MSB] | (&sr_reg[7:5]); // see RULE14
    assign busy = (state_reg != ST_IDLE);

endmodule

// [bench/csa_core_properties.sv]
// Purpose: concurrent checks on the ports of the cpu status / alu core
// Assumes: one clock domain, arst_n asynchronous active low
// Notes: helper flops track the ahb data phase, as the design sees it
`timescale 1ns/1ns
`include "csa_map.vh"
module csa_core_props (
    input wire clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire nesting_disable,
    input wire irq_request,
    input wire user_irq_disabled,
    input wire [3:0] cpu_level,
    input wire busy
);
    logic rd_phase;
    logic st_phase;
    logic cmd_phase;
    logic wide_phase;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // data phase tracking
    // ----------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_phase <= 1'b0;
            st_phase <= 1'b0;
            cmd_phase <= 1'b0;
            wide_phase <= 1'b0;
        end else begin
            wide_phase <= hsel & hready & htrans[1] & ~hwrite &
                (haddr[7:0] == `CSA_OFS_XLATE || haddr[7:0] == `CSA_OFS_PC);
            rd_phase <= hsel & hready & htrans[1] & ~hwrite;
            st_phase <= hsel & hready & htrans[1] & ~hwrite & (haddr[7:0] == `CSA_OFS_STATUS);
            cmd_phase <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == `CSA_OFS_CMD);
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_zero_wait_okay: assert property (hreadyout && !hresp)
        else $error("slave inserted a wait state or an error response");
    a_upper_half_zero: assert property (!wide_phase |-> hrdata[31:16] == 16'h0000)
        else $error("upper read data bits not zero");
    a_idle_read_zero: assert property (!rd_phase |-> hrdata == 32'h0000_0000)
        else $error("read data driven outside a read data phase");
    a_status_top_zero: assert property (st_phase |-> hrdata[15:9] == 7'h00)
        else $error("status bits 15 to 9 not zero");
    a_user_irq_off: assert property (user_irq_disabled == (cpu_level[3] | (cpu_level[2:0] == 3'b111)))
        else $error("user interrupt disable disagrees with cpu level");
    a_msb_clear_only: assert property (!$rose(cpu_level[3]))
        else $error("priority msb was set");
    a_level_locked: assert property (nesting_disable ##1 nesting_disable |-> $stable(cpu_level[2:0]))
        else $error("priority field changed while nesting disabled");
    a_single_cycle_op: assert property (cmd_phase && hwdata[3:0] <= `CSA_OP_SHIFT && !busy |=> !busy)
        else $error("single cycle operation raised busy");
    a_divide_length: assert property (
        cmd_phase && hwdata[3:0] == `CSA_OP_DIVU && !busy && !irq_request |=> busy [*8] ##10 busy ##1 !busy)
        else $error("divide busy span is not 18 cycles");
    a_busy_bounded: assert property ($rose(busy) |-> ##[1:300] !busy)
        else $error("busy never dropped");
endmodule

bind csa_core csa_core_props csa_core_props_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .nesting_disable(nesting_disable), .irq_request(irq_request),
    .user_irq_disabled(user_irq_disabled), .cpu_level(cpu_level), .busy(busy));

// [bench/test_cpu_core_status_alu.sv]
// Purpose: self-checking bench for the cpu status / alu core over ahb-lite
// Assumes: zero wait states, read data captured at the data phase edge
// Notes: flag expectations chain from one operation to the next
`timescale 1ns/1ns
`include "csa_map.vh"
module test_cpu_core_status_alu;
    logic clk, arst_n, hsel, hwrite, nesting_disable, irq_request;
    logic [31:0] haddr, hwdata, hrdata_smp, x;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire [31:0] hrdata;
    wire [3:0] cpu_level;
    wire hreadyout, hresp, user_irq_disabled, busy;
    int error_cnt, comparisons, busy_cycles, irq_cnt;

    csa_core csa_core_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .nesting_disable(nesting_disable), .irq_request(irq_request),
        .user_irq_disabled(user_irq_disabled), .cpu_level(cpu_level), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // capture with nba so the task reads the pre-edge value, free of races
    always @(posedge clk) begin
        hrdata_smp <= hrdata;
        irq_request <= (irq_cnt != 0);
        if (irq_cnt != 0) begin
            irq_cnt <= irq_cnt - 1;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        @(negedge clk);
        rd = hrdata_smp;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] y;
        ahb(1'b1, a, d, y);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] y;
        ahb(1'b0, a, 32'h0000_0000, y);
        chk(what, e, y);
    endtask
    task automatic settle(input int stalls);
        irq_cnt = stalls;
        busy_cycles = 0;
        while (busy === 1'b1 && busy_cycles < 500) begin
            busy_cycles++;
            @(negedge clk);
        end
    endtask
    task automatic alu(input logic [31:0] cmd, a, b, e_lo, input logic [7:0] a2, input logic [31:0] e2,
            input int stalls);
        wr(`CSA_OFS_OPA, a);
        wr(`CSA_OFS_OPB, b);
        wr(`CSA_OFS_CMD, cmd);
        settle(stalls);
        rdc("result", `CSA_OFS_RES, e_lo);
        rdc("status or high word", a2, e2);
    endtask
    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        #200000;
        error_cnt++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        nesting_disable = 1'b0;
        irq_request = 1'b0;
        irq_cnt = 0;
        error_cnt = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        rdc("status reset", `CSA_OFS_STATUS, 32'h0000_0000);
        rdc("control reset", `CSA_OFS_CORE, 32'h0000_0000);
        rdc("unmapped", 8'h3c, 32'h0000_0000);
        $display("test reset done");
        wr(`CSA_OFS_STATUS, 32'h0000_0002);
        alu(32'h0000_0000, 32'h0000_7fff, 32'h0000_0001, 32'h0000_8000, 0, 32'h0000_010c, 0);
        chk("add busy cycles", 32'h0000_0000, busy_cycles);
        alu(32'h0000_0000, 32'h0000_ffff, 32'h0000_0001, 32'h0000_0000, 0, 32'h0000_0101, 0);
        alu(32'h0000_0001, 32'h0000_0000, 32'h0000_0001, 32'h0000_ffff, 0, 32'h0000_0109, 0);
        alu(32'h0000_0001, 32'h0000_8000, 32'h0000_0001, 32'h0000_7fff, 0, 32'h0000_0104, 0);
        alu(32'h0000_0000, 32'h0000_007f, 32'h0000_0001, 32'h0000_0080, 0, 32'h0000_0000, 0);
        alu(32'h0000_0010, 32'h0000_007f, 32'h0000_0001, 32'h0000_0080, 0, 32'h0000_010c, 0);
        alu(32'h0000_0002, 32'h0000_a5a5, 32'h0000_0ff0, 32'h0000_05a0, 0, 32'h0000_0104, 0);
        alu(32'h0000_0003, 32'h0000_a5a5, 32'h0000_0ff0, 32'h0000_aff5, 0, 32'h0000_010c, 0);
        alu(32'h0000_0004, 32'h0000_a5a5, 32'h0000_0ff0, 32'h0000_aa55, 0, 32'h0000_010c, 0);
        $display("test flags done");
        alu(32'h0000_0005, 32'h0000_ffff, 32'h0000_0002, 32'h0000_fffe, 8'h18, 32'h0000_0001, 0);
        alu(32'h0000_0025, 32'h0000_ffff, 32'h0000_0002, 32'h0000_fffe, 8'h18, 32'h0000_ffff, 0);
        alu(32'h0000_0045, 32'h0000_ffff, 32'h0000_0002, 32'h0000_fffe, 8'h18, 32'h0000_0001, 0);
        alu(32'h0000_0065, 32'h0000_ffff, 32'h0000_0002, 32'h0000_fffe, 8'h18, 32'h0000_ffff, 0);
        alu(32'h0000_0006, 32'h0000_8001, 32'h0000_0004, 32'h0000_0800, 0, 32'h0000_0104, 0);
        alu(32'h0000_0026, 32'h0000_8001, 32'h0000_0004, 32'h0000_f800, 0, 32'h0000_010c, 0);
        alu(32'h0000_0006, 32'h0000_8001, 32'h0000_fffc, 32'h0000_0010, 0, 32'h0000_0104, 0);
        alu(32'h0000_0006, 32'h0000_8001, 32'h0000_0010, 32'h0000_0000, 0, 32'h0000_0104, 0);
        $display("test multiply and shift done");
        alu(32'h0000_0007, 32'h0000_0064, 32'h0000_0007, 32'h0000_000e, 8'h18, 32'h0000_0002, 0);
        chk("divide busy cycles", 32'h0000_0012, busy_cycles);
        alu(32'h0000_0008, 32'h0000_ff9c, 32'h0000_0007, 32'h0000_fff2, 8'h18, 32'h0000_fffe, 3);
        chk("stalled divide busy cycles", 32'h0000_0015, busy_cycles);
        wr(`CSA_OFS_OPA, 32'h0000_0003);
        wr(`CSA_OFS_CMD, 32'h0000_0009);
        settle(0);
        chk("repeat busy cycles", 32'h0000_0004, busy_cycles);
        wr(`CSA_OFS_OPA, 32'h0000_0014);
        wr(`CSA_OFS_CMD, 32'h0000_0009);
        ahb(1'b0, `CSA_OFS_STATUS, 32'h0000_0000, x);
        chk("loop active", 32'h0000_0001, {31'h0000_0000, x[4]});
        settle(0);
        $display("test divide and repeat done");
        wr(`CSA_OFS_DMARAM, 32'h0000_0005);
        wr(`CSA_OFS_CTRL, 32'h0000_1234);
        rdc("dma", `CSA_OFS_DMARAM, 32'h0000_1234);
        wr(`CSA_OFS_PAGE, 32'h0000_0005);
        wr(`CSA_OFS_DADDR, 32'h0000_8004);
        rdc("linear", `CSA_OFS_XLATE, 32'h0000_8004);
        wr(`CSA_OFS_CORE, 32'h0000_0004);
        rdc("window", `CSA_OFS_XLATE, 32'h0005_0008);
        wr(`CSA_OFS_STATUS, 32'h0000_fff0);
        rdc("status write", `CSA_OFS_STATUS, 32'h0000_01e0);
        chk("cpu level", 32'h0000_0007, {28'h000_0000, cpu_level});
        chk("user irq off", 32'h0000_0001, {31'h0000_0000, user_irq_disabled});
        @(posedge clk);
        nesting_disable <= 1'b1;
        wr(`CSA_OFS_STATUS, 32'h0000_0000);
        rdc("locked status", `CSA_OFS_STATUS, 32'h0000_00e0);
        @(posedge clk);
        nesting_disable <= 1'b0;
        wr(`CSA_OFS_STATUS, 32'h0000_0060);
        rdc("unlocked status", `CSA_OFS_STATUS, 32'h0000_0060);
        chk("user irq on", 32'h0000_0000, {31'h0000_0000, user_irq_disabled});
        wr(`CSA_OFS_CORE, 32'h0000_000c);
        rdc("control set", `CSA_OFS_CORE, 32'h0000_0004);
        chk("cpu level low", 32'h0000_0003, {28'h000_0000, cpu_level});
        wr(`CSA_OFS_CORE, 32'h0000_0000);
        rdc("control clear", `CSA_OFS_CORE, 32'h0000_0000);
        $display("test priority and control done");
        test_done();
    end
endmodule
